// ### lwk_pkg.sv
package lwk_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int          CLK_HZ       = 100_000_000;
	localparam int          DEB_TIME_MS  = 10;
	localparam int          DEB_CYC      = CLK_HZ / 1000 * DEB_TIME_MS;
	localparam int          POLL_TIME_MS = 100;
	localparam int          POLL_CYC     = CLK_HZ / 1000 * POLL_TIME_MS;
	localparam int          BRK_MIN_US   = 500;
	localparam int          BRK_MIN_CYC  = CLK_HZ / 1_000_000 * BRK_MIN_US;
	localparam logic [15:0] BAUD_RST     = 16'h028B;  // 8x clock for 19200 bit/s
	localparam logic [2:0]  SUB_MID      = 3'h4;
	localparam logic [2:0]  SUB_LAST     = 3'h7;
	localparam logic [3:0]  BRK_BITS     = 4'hD;
	localparam logic [3:0]  LAST_BIT     = 4'h9;
	localparam logic [4:0]  TO_BITS      = 5'h14;
	localparam int          SYNC_SHIFT   = 6;         // eight bits over 64 sub-ticks

	// ----------------------------------------
	// frame content
	// ----------------------------------------
	localparam logic [7:0]  SYNC_BYTE = 8'h55;
	localparam logic [5:0]  ID_STAT   = 6'h01;
	localparam logic [5:0]  ID_SET    = 6'h02;
	localparam int          D_RUN     = 7;
	localparam int          D_DIR     = 6;
	localparam int          D_MODE    = 4;
	localparam int          D_SET     = 0;

	// ----------------------------------------
	// keys and registers
	// ----------------------------------------
	localparam int          K_RUN    = 0;
	localparam int          K_MODE   = 1;
	localparam int          K_SET    = 2;
	localparam int          K_DIR    = 3;
	localparam logic [7:0]  A_CTRL   = 8'h00;
	localparam logic [7:0]  A_BAUD   = 8'h04;
	localparam logic [7:0]  A_STAT   = 8'h08;
	localparam logic [7:0]  A_IEN    = 8'h0C;
	localparam logic [7:0]  A_ICLR   = 8'h10;
	localparam logic [7:0]  A_RXD    = 8'h14;
	localparam logic [7:0]  A_SEL    = 8'h18;
	localparam int          ST_DONE  = 0;
	localparam int          ST_BERR  = 1;
	localparam int          ST_KEY   = 2;
	localparam int          ST_RXOK  = 3;
	localparam int          ST_CERR  = 4;
	localparam int          ST_TOUT  = 5;
	localparam int          NST      = 6;

	typedef enum logic [1:0] {MODE_CONT, MODE_WIPE, MODE_WASH} lwk_mode_e;

	// identifier with its two parity bits
	function automatic logic [7:0] pid_f(input logic [5:0] id);
		pid_f = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction : pid_f

	// inverted sum over the single data byte
	function automatic logic [7:0] chk_f(input logic [7:0] d);
		chk_f = ~d;
	endfunction : chk_f

endpackage : lwk_pkg

// ### lwk_if.sv
// ----------------------------------------
// single-wire bus, wired-and of both ends
// ----------------------------------------
interface lwk_if;
	logic m_tx;
	logic m_oe_n;
	logic s_tx;
	logic s_oe_n;
	logic bus;

	// an end that does not drive leaves the pulled-up wire high
	assign bus = (m_oe_n | m_tx) & (s_oe_n | s_tx);

	modport master (output m_tx, output m_oe_n, input bus);
	modport slave  (output s_tx, output s_oe_n, input bus);
endinterface : lwk_if

// ### lwk_master.sv
// Local design decisions: register access over APB and the placing of the registers.
module lwk_master #(
	parameter int DEB_CYC  = lwk_pkg::DEB_CYC,
	parameter int POLL_CYC = lwk_pkg::POLL_CYC
) (
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	// keypad and leds
	input  wire logic [3:0]  keys,
	output logic      [1:0]  led_mode,
	output logic      [1:0]  led_set,
	// bus
	lwk_if.master            lin
);
	localparam int CW = $clog2(DEB_CYC + 1);
	localparam int PW = $clog2(POLL_CYC + 1);

	typedef enum logic [2:0] {F_IDLE, F_BRK, F_DEL, F_TX, F_RX} lwk_fst_e;

	lwk_fst_e            fs_r;
	lwk_pkg::lwk_mode_e  mode_r;
	logic [3:0]          key_ev;
	logic                run_r, dir_r, pen_r, bq_r, drv_r, f2_r, rxw_r;
	logic                f1_pend_r, f2_pend_r;
	logic [1:0]          set_r, idx_r;
	logic [15:0]         baud_r, bd_r;
	logic [2:0]          sub_r;
	logic [3:0]          bitn_r;
	logic [4:0]          wait_r;
	logic [9:0]          sh_r;
	logic [7:0]          data_r, rxs_r, rxd_r;
	localparam int       NST_W = lwk_pkg::NST;
	logic [PW-1:0]       pcnt_r;
	logic [NST_W-1:0]    st_r, ien_r, ev_r;
	logic                tick, bit_tick, mid, rsync, key_hit, acc;
	logic                prdy_r, pserr_r, irq_r;
	logic [31:0]         prdata_r;
	logic [1:0]          ledm_r, leds_r;

	function automatic logic [7:0] tx_byte(input logic [1:0] i, input logic f2,
					       input logic [7:0] d);
		unique case (i)
			2'h0: tx_byte = lwk_pkg::SYNC_BYTE;
			2'h1: tx_byte = lwk_pkg::pid_f(f2 ? lwk_pkg::ID_SET : lwk_pkg::ID_STAT);
			2'h2: tx_byte = d;
			2'h3: tx_byte = lwk_pkg::chk_f(d);
		endcase
	endfunction : tx_byte

	// ----------------------------------------
	// keys
	// ----------------------------------------
	// a press is taken only after the level has held for the whole window
	for (genvar g = 0; g < 4; g++) begin : g_deb
		logic [CW-1:0] cnt_r;
		logic          st_k_r, ev_k_r;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_r  <= '0;
				st_k_r <= 1'b0;
				ev_k_r <= 1'b0;
			end else if (ce) begin
				ev_k_r <= 1'b0;
				if (keys[g] == st_k_r) begin
					cnt_r <= '0;
				end else if (cnt_r == CW'(DEB_CYC - 1)) begin
					cnt_r  <= '0;
					st_k_r <= keys[g];
					ev_k_r <= keys[g];
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
		end
		assign key_ev[g] = ev_k_r;
	end

	// run/stop acts always so a running motor can be stopped; others only when stopped
	assign key_hit = run_r ? key_ev[lwk_pkg::K_RUN] : |key_ev;

	// selection state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r  <= 1'b0;
			dir_r  <= 1'b0;
			set_r  <= 2'h0;
			mode_r <= lwk_pkg::MODE_CONT;
		end else if (ce) begin
			if (key_ev[lwk_pkg::K_RUN])
				run_r <= ~run_r;
			if (!run_r) begin
				if (key_ev[lwk_pkg::K_MODE]) begin
					unique case (mode_r)
						lwk_pkg::MODE_CONT: mode_r <= lwk_pkg::MODE_WIPE;
						lwk_pkg::MODE_WIPE: mode_r <= lwk_pkg::MODE_WASH;
						default:            mode_r <= lwk_pkg::MODE_CONT;
					endcase
				end
				if (key_ev[lwk_pkg::K_SET])
					set_r <= set_r + 2'h1;
				if (key_ev[lwk_pkg::K_DIR])
					dir_r <= ~dir_r;
			end
		end
	end

	// leds trail the selection by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ledm_r <= 2'h0;
			leds_r <= 2'h0;
		end else if (ce) begin
			leds_r <= set_r;
			unique case (mode_r)
				lwk_pkg::MODE_CONT: ledm_r <= 2'h1;
				lwk_pkg::MODE_WIPE: ledm_r <= 2'h2;
				default:            ledm_r <= 2'h3;
			endcase
		end
	end

	// ----------------------------------------
	// frame requests
	// ----------------------------------------
	// a due poll stays pending until the bus is idle; settings go first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcnt_r    <= '0;
			f1_pend_r <= 1'b0;
			f2_pend_r <= 1'b0;
		end else if (ce) begin
			pcnt_r <= (pcnt_r == PW'(POLL_CYC - 1)) ? '0 : pcnt_r + 1'b1;
			if (pen_r && pcnt_r == PW'(POLL_CYC - 1))
				f1_pend_r <= 1'b1;
			else if (fs_r == F_IDLE && !f2_pend_r)
				f1_pend_r <= 1'b0;
			if (key_hit)
				f2_pend_r <= 1'b1;
			else if (fs_r == F_IDLE)
				f2_pend_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// baud and bit-time counters
	// ----------------------------------------
	assign tick     = (bd_r == 16'h0000);
	assign bit_tick = tick && sub_r == lwk_pkg::SUB_LAST;
	assign mid      = tick && sub_r == lwk_pkg::SUB_MID;
	assign rsync    = (fs_r == F_IDLE) || (fs_r == F_RX && rxw_r && bq_r && !lin.bus);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bd_r  <= 16'h0000;
			sub_r <= 3'h0;
			bq_r  <= 1'b1;
		end else if (ce) begin
			bq_r <= lin.bus;
			if (rsync || tick)
				bd_r <= baud_r - 16'h0001;
			else
				bd_r <= bd_r - 16'h0001;
			if (rsync)
				sub_r <= 3'h0;
			else if (tick)
				sub_r <= sub_r + 3'h1;
		end
	end

	// ----------------------------------------
	// frame engine
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_r   <= F_IDLE;
			drv_r  <= 1'b1;
			f2_r   <= 1'b0;
			rxw_r  <= 1'b0;
			idx_r  <= 2'h0;
			bitn_r <= 4'h0;
			wait_r <= 5'h00;
			sh_r   <= 10'h3FF;
			data_r <= 8'h00;
			rxs_r  <= 8'h00;
			rxd_r  <= 8'h00;
			ev_r   <= '0;
		end else if (ce) begin
			ev_r <= '0;
			ev_r[lwk_pkg::ST_KEY] <= key_hit;
			unique case (fs_r)
				F_IDLE: begin
					if (f2_pend_r || f1_pend_r) begin
						f2_r   <= f2_pend_r;
						data_r <= {run_r, dir_r, mode_r, 2'h0, set_r};
						drv_r  <= 1'b0;
						bitn_r <= 4'h0;
						fs_r   <= F_BRK;
					end
				end
				F_BRK: if (bit_tick) begin
					bitn_r <= bitn_r + 4'h1;
					if (bitn_r == lwk_pkg::BRK_BITS - 4'h1) begin
						drv_r <= 1'b1;
						fs_r  <= F_DEL;
					end
				end
				F_DEL: if (bit_tick) begin
					sh_r   <= {1'b1, lwk_pkg::SYNC_BYTE, 1'b0};
					drv_r  <= 1'b0;
					idx_r  <= 2'h0;
					bitn_r <= 4'h0;
					fs_r   <= F_TX;
				end
				F_TX: begin
					if (mid && lin.bus != drv_r)
						ev_r[lwk_pkg::ST_BERR] <= 1'b1;
					if (bit_tick) begin
						if (bitn_r != lwk_pkg::LAST_BIT) begin
							sh_r   <= {1'b1, sh_r[9:1]};
							drv_r  <= sh_r[1];
							bitn_r <= bitn_r + 4'h1;
						end else if (f2_r && idx_r == 2'h3) begin
							ev_r[lwk_pkg::ST_DONE] <= 1'b1;
							fs_r <= F_IDLE;
						end else if (!f2_r && idx_r == 2'h1) begin
							rxw_r  <= 1'b1;
							idx_r  <= 2'h0;
							wait_r <= 5'h00;
							fs_r   <= F_RX;
						end else begin
							sh_r   <= {1'b1, tx_byte(idx_r + 2'h1, f2_r, data_r), 1'b0};
							drv_r  <= 1'b0;
							idx_r  <= idx_r + 2'h1;
							bitn_r <= 4'h0;
						end
					end
				end
				F_RX: begin
					if (rxw_r) begin
						if (rsync) begin
							rxw_r  <= 1'b0;
							bitn_r <= 4'h0;
						end else if (bit_tick) begin
							wait_r <= wait_r + 5'h01;
							if (wait_r == lwk_pkg::TO_BITS - 5'h01) begin
								ev_r[lwk_pkg::ST_TOUT] <= 1'b1;
								fs_r <= F_IDLE;
							end
						end
					end else if (mid) begin
						sh_r   <= {lin.bus, sh_r[9:1]};
						bitn_r <= bitn_r + 4'h1;
						if (bitn_r == 4'h0 && lin.bus) begin
							rxw_r <= 1'b1;  // glitch, not a start bit
						end else if (bitn_r == lwk_pkg::LAST_BIT) begin
							rxw_r  <= 1'b1;
							wait_r <= 5'h00;
							if (idx_r == 2'h0) begin
								rxs_r <= sh_r[9:2];
								idx_r <= 2'h1;
							end else begin
								if (sh_r[9:2] == lwk_pkg::chk_f(rxs_r)) begin
									rxd_r <= rxs_r;
									ev_r[lwk_pkg::ST_RXOK] <= 1'b1;
								end else begin
									ev_r[lwk_pkg::ST_CERR] <= 1'b1;
								end
								fs_r <= F_IDLE;
							end
						end
					end
				end
				default: fs_r <= F_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// apb registers and interrupt
	// ----------------------------------------
	// one wait-free access: ready rises in the first access cycle
	assign acc = psel && penable && prdy_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdy_r   <= 1'b0;
			pserr_r  <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pen_r    <= 1'b0;
			baud_r   <= lwk_pkg::BAUD_RST;
			ien_r    <= '0;
			st_r     <= '0;
			irq_r    <= 1'b0;
		end else if (ce) begin
			prdy_r  <= psel && !penable;
			pserr_r <= 1'b0;
			if (psel && !penable) begin
				prdata_r <= 32'h0000_0000;
				unique case (paddr)
					lwk_pkg::A_CTRL: prdata_r[0]    <= pen_r;
					lwk_pkg::A_BAUD: prdata_r[15:0] <= baud_r;
					lwk_pkg::A_STAT: prdata_r[NST_W-1:0] <= st_r;
					lwk_pkg::A_IEN:  prdata_r[NST_W-1:0] <= ien_r;
					lwk_pkg::A_ICLR: prdata_r <= 32'h0000_0000;
					lwk_pkg::A_RXD:  prdata_r[7:0]  <= rxd_r;
					lwk_pkg::A_SEL:  prdata_r[7:0]  <= {run_r, dir_r, mode_r, 2'h0, set_r};
					default:         pserr_r        <= 1'b1;
				endcase
			end
			if (acc && pwrite) begin
				if (paddr == lwk_pkg::A_CTRL) pen_r  <= pwdata[0];
				if (paddr == lwk_pkg::A_BAUD) baud_r <= pwdata[15:0];
				if (paddr == lwk_pkg::A_IEN)  ien_r  <= pwdata[NST_W-1:0];
			end
			// a new event wins over a clear in the same cycle
			st_r  <= (st_r & ~((acc && pwrite && paddr == lwk_pkg::A_ICLR) ?
					  pwdata[NST_W-1:0] : '0)) | ev_r;
			irq_r <= |(st_r & ien_r);
		end
	end

	assign prdata     = prdata_r;
	assign pready     = prdy_r;
	assign pslverr    = pserr_r;
	assign irq        = irq_r;
	assign led_mode   = ledm_r;
	assign led_set    = leds_r;
	assign lin.m_tx   = drv_r;
	assign lin.m_oe_n = drv_r;

endmodule : lwk_master

// ### lwk_slave.sv
module lwk_slave #(
	parameter int BRK_MIN_CYC = lwk_pkg::BRK_MIN_CYC
) (
	// clock, reset, enable
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	// bus
	lwk_if.slave            lin,
	// motor side
	input  wire logic [7:0] motor_st,
	output logic            run,
	output logic            dir,
	output logic      [1:0] mode,
	output logic      [1:0] set,
	output logic            err_pid,
	output logic            err_chk,
	output logic            tout
);
	localparam int BW = $clog2(BRK_MIN_CYC + 1);

	typedef enum logic [1:0] {S_BRK, S_SYN, S_RX, S_TX} lwk_sst_e;

	lwk_sst_e    ss_r;
	logic [BW-1:0] low_r;
	logic [15:0] tm_r, div_r, bd_r;
	logic [2:0]  sub_r, fe_r;
	logic [3:0]  bitn_r;
	logic [4:0]  wait_r;
	logic [1:0]  idx_r;
	logic [9:0]  sh_r;
	logic [7:0]  pend_r, txd_r, cfg_r;
	logic        bq_r, drv_r, rxw_r, epid_r, echk_r, eto_r;
	logic        tick, bit_tick, mid, rsync, fall;

	assign fall     = bq_r && !lin.bus;
	assign tick     = (bd_r == 16'h0000);
	assign bit_tick = tick && sub_r == lwk_pkg::SUB_LAST;
	assign mid      = tick && sub_r == lwk_pkg::SUB_MID;
	assign rsync    = ss_r == S_RX && rxw_r && fall;

	// ----------------------------------------
	// baud and bit-time counters
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bd_r  <= 16'h0000;
			sub_r <= 3'h0;
			bq_r  <= 1'b1;
		end else if (ce) begin
			bq_r  <= lin.bus;
			bd_r  <= (rsync || tick) ? div_r - 16'h0001 : bd_r - 16'h0001;
			sub_r <= rsync ? 3'h0 : (tick ? sub_r + 3'h1 : sub_r);
		end
	end

	// ----------------------------------------
	// frame engine
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_r   <= S_BRK;
			low_r  <= '0;
			tm_r   <= 16'h0000;
			div_r  <= lwk_pkg::BAUD_RST;
			fe_r   <= 3'h0;
			bitn_r <= 4'h0;
			wait_r <= 5'h00;
			idx_r  <= 2'h0;
			sh_r   <= 10'h3FF;
			pend_r <= 8'h00;
			txd_r  <= 8'h00;
			cfg_r  <= 8'h00;
			drv_r  <= 1'b1;
			rxw_r  <= 1'b0;
			epid_r <= 1'b0;
			echk_r <= 1'b0;
			eto_r  <= 1'b0;
		end else if (ce) begin
			epid_r <= 1'b0;
			echk_r <= 1'b0;
			eto_r  <= 1'b0;
			tm_r   <= tm_r + 16'h0001;
			unique case (ss_r)
				S_BRK: begin
					drv_r <= 1'b1;
					if (!lin.bus) begin
						if (low_r != BW'(BRK_MIN_CYC)) low_r <= low_r + 1'b1;
					end else begin
						low_r <= '0;
						if (low_r == BW'(BRK_MIN_CYC)) begin
							fe_r <= 3'h0;
							ss_r <= S_SYN;
						end
					end
				end
				// five falling edges of the sync byte span eight bit times
				S_SYN: if (fall) begin
					fe_r <= fe_r + 3'h1;
					// the edge cycle itself counts, else the divider comes out one short
					if (fe_r == 3'h0) tm_r <= 16'h0001;
					if (fe_r == 3'h4) begin
						div_r  <= tm_r >> lwk_pkg::SYNC_SHIFT;
						idx_r  <= 2'h0;
						rxw_r  <= 1'b1;
						wait_r <= 5'h00;
						ss_r   <= S_RX;
					end
				end
				S_RX: begin
					if (rxw_r) begin
						if (rsync) begin
							rxw_r  <= 1'b0;
							bitn_r <= 4'h0;
						end else if (bit_tick) begin
							wait_r <= wait_r + 5'h01;
							if (wait_r == lwk_pkg::TO_BITS - 5'h01) begin
								eto_r <= 1'b1;
								ss_r  <= S_BRK;
							end
						end
					end else if (mid) begin
						sh_r   <= {lin.bus, sh_r[9:1]};
						bitn_r <= bitn_r + 4'h1;
						if (bitn_r == 4'h0 && lin.bus) begin
							rxw_r <= 1'b1;
						end else if (bitn_r == lwk_pkg::LAST_BIT) begin
							rxw_r  <= 1'b1;
							wait_r <= 5'h00;
							idx_r  <= idx_r + 2'h1;
							unique case (idx_r)
								2'h0: begin
									if (sh_r[9:2] == lwk_pkg::pid_f(lwk_pkg::ID_STAT)) begin
										txd_r  <= motor_st;
										sh_r   <= {1'b1, motor_st, 1'b0};
										bitn_r <= 4'h0;
										ss_r   <= S_TX;
									end else if (sh_r[9:2] != lwk_pkg::pid_f(lwk_pkg::ID_SET)) begin
										epid_r <= sh_r[9:2] != lwk_pkg::pid_f(sh_r[7:2]);
										ss_r   <= S_BRK;
									end
								end
								2'h1: pend_r <= sh_r[9:2];
								default: begin
									if (sh_r[9:2] != lwk_pkg::chk_f(pend_r))
										echk_r <= 1'b1;
									else if (pend_r[lwk_pkg::D_RUN])
										cfg_r <= pend_r;
									else
										cfg_r[lwk_pkg::D_RUN] <= 1'b0;
									ss_r <= S_BRK;
								end
							endcase
						end
					end
				end
				// eleven bit ticks: ten bits out, then release the wire
				S_TX: if (bit_tick) begin
					bitn_r <= bitn_r + 4'h1;
					if (bitn_r == 4'hA) begin
						drv_r  <= 1'b1;
						bitn_r <= 4'h0;
						sh_r   <= {1'b1, lwk_pkg::chk_f(txd_r), 1'b0};
						if (idx_r == 2'h2) ss_r <= S_BRK;
						idx_r  <= idx_r + 2'h1;
					end else begin
						drv_r <= sh_r[0];
						sh_r  <= {1'b1, sh_r[9:1]};
					end
				end
				default: ss_r <= S_BRK;
			endcase
		end
	end

	assign run        = cfg_r[lwk_pkg::D_RUN];
	assign dir        = cfg_r[lwk_pkg::D_DIR];
	assign mode       = cfg_r[lwk_pkg::D_MODE +: 2];
	assign set        = cfg_r[lwk_pkg::D_SET +: 2];
	assign err_pid    = epid_r;
	assign err_chk    = echk_r;
	assign tout       = eto_r;
	assign lin.s_tx   = drv_r;
	assign lin.s_oe_n = drv_r;

endmodule : lwk_slave

// ### lwk_properties.sv
// ----------------------------------------
// wire-level checks on the joined link
// ----------------------------------------
module lwk_properties #(
	parameter int BAUD = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// both ends of the wire
	input wire logic m_tx,
	input wire logic m_oe_n,
	input wire logic s_tx,
	input wire logic s_oe_n
);
	localparam int          HALF   = 4 * BAUD;
	localparam int          BIT    = 8 * BAUD;
	localparam logic [15:0] BIT_W  = 16'(BIT);
	localparam logic [15:0] LONG_W = 16'(9 * BIT);
	localparam logic [15:0] BRK_W  = 16'(13 * BIT);

	logic [15:0] m_low_r;
	logic [15:0] m_high_r;
	logic [15:0] s_low_r;
	logic        brk_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// run lengths of both master levels and of the slave low level, in clock cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_low_r  <= 16'h0000;
			m_high_r <= 16'h0000;
			s_low_r  <= 16'h0000;
		end else begin
			m_low_r  <= m_tx ? 16'h0000 : m_low_r + 16'h0001;
			m_high_r <= m_tx ? m_high_r + 16'h0001 : 16'h0000;
			s_low_r  <= s_tx ? 16'h0000 : s_low_r + 16'h0001;
		end
	end

	// a finished break is remembered until the delimiter ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brk_r <= 1'b0;
		end else if (m_tx && m_low_r == BRK_W) begin
			brk_r <= 1'b1;
		end else if (!m_tx) begin
			brk_r <= 1'b0;
		end
	end

	// sync byte at mid bit: start, alternating data lsb first, stop
	sequence sync_s;
		##HALF !m_tx ##BIT m_tx ##BIT !m_tx ##BIT m_tx ##BIT !m_tx
		##BIT m_tx ##BIT !m_tx ##BIT m_tx ##BIT !m_tx ##BIT m_tx;
	endsequence

	chk_oe_tracks_tx: assert property (m_oe_n == m_tx)
		else $error("master enable differs from its data");
	chk_idle_after_reset: assert property ($rose(presetn) |-> m_tx && s_tx)
		else $error("wire not released after reset");
	chk_bit_whole: assert property ($rose(m_tx) |-> m_low_r % BIT_W == 16'h0000)
		else $error("master low run not whole bit times");
	chk_break_length: assert property ($rose(m_tx) && m_low_r > LONG_W |-> m_low_r == BRK_W)
		else $error("break length wrong");
	chk_delim_length: assert property ($fell(m_tx) && brk_r |-> m_high_r == BIT_W)
		else $error("delimiter length wrong");
	chk_sync_after_break: assert property ($fell(m_tx) && brk_r |-> sync_s)
		else $error("sync byte wrong after break");
	chk_slave_bit_whole: assert property ($rose(s_tx) |-> s_low_r % BIT_W == 16'h0000)
		else $error("slave low run not whole bit times");
	chk_one_talker: assert property (!s_tx |-> m_tx)
		else $error("both ends pull the wire low");
endmodule : lwk_properties

// ### lin_master_wiper_keypad_bench.sv
module lin_master_wiper_keypad_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
	logic        run, dir, err_pid, err_chk, tout, slave_bad, ce;
	logic [7:0]  paddr, motor_st;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  keys;
	logic [1:0]  led_mode, led_set, mode, set;
	int          num_errors, checks;

	// ----------------------------------------
	// both ends joined on one wire
	// ----------------------------------------
	lwk_if i_lwk_if ();
	lwk_master #(.DEB_CYC(4), .POLL_CYC(3000)) i_lwk_master (
		.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .keys(keys),
		.led_mode(led_mode), .led_set(led_set), .lin(i_lwk_if.master));
	// break threshold sits between a nine-bit low run and the break
	lwk_slave #(.BRK_MIN_CYC(320)) i_lwk_slave (
		.pclk(pclk), .presetn(presetn), .ce(ce), .lin(i_lwk_if.slave),
		.motor_st(motor_st), .run(run), .dir(dir), .mode(mode), .set(set),
		.err_pid(err_pid), .err_chk(err_chk), .tout(tout));
	lwk_properties #(.BAUD(4)) i_lwk_properties (
		.pclk(pclk), .presetn(presetn), .m_tx(i_lwk_if.m_tx), .m_oe_n(i_lwk_if.m_oe_n),
		.s_tx(i_lwk_if.s_tx), .s_oe_n(i_lwk_if.s_oe_n));

	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// slave error pulses last one cycle, so latch them
	always @(posedge pclk) begin
		if (err_pid === 1'b1 || err_chk === 1'b1 || tout === 1'b1) slave_bad <= 1'b1;
	end

	task automatic finish_test;
		$display("mismatches %0d of %0d checks", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	// one transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// only the watchdog ends a wait that never sees ready
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		check("pready wait", 32'h0000_0001, 32'(n));
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// waits for a status bit, then clears all status
	task automatic wait_stat(input int b);
		int n;
		n = 0;
		do begin
			apb(1'b0, lwk_pkg::A_STAT, 32'h0000_0000, rd);
			n++;
		end while (rd[b] !== 1'b1 && n < 2000);
		check("status bit", 32'h0000_0001, 32'(rd[b]));
		check("link errors", 32'h0000_0000, rd & 32'h0000_0032);
		if (b == 0) check("irq set", 32'h0000_0001, 32'(irq));
		apb(1'b1, lwk_pkg::A_ICLR, 32'h0000_003F, rd);
		repeat (40) @(posedge pclk);
		if (b == 0) check("irq clear", 32'h0000_0000, 32'(irq));
	endtask : wait_stat

	// held well past the debounce count, then released
	task automatic press(input int k, input logic frame);
		keys[k] <= 1'b1;
		repeat (10) @(posedge pclk);
		keys[k] <= 1'b0;
		repeat (10) @(posedge pclk);
		if (frame) wait_stat(0);
	endtask : press

	// hang guard, well beyond the expected run length
	initial begin
		#600_000;
		num_errors++;
		finish_test();
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, keys, slave_bad} = '0;
		motor_st = 8'h00;
		ce = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0000_0000, rd);
			check("reset value", (i == 1) ? 32'h0000_028B : 32'h0000_0000, rd);
		end
		apb(1'b0, 8'h1C, 32'h0000_0000, rd);
		check("unmapped", 32'h0000_0001, {rd[30:0], last_err});
		apb(1'b1, lwk_pkg::A_BAUD, 32'h0000_0004, rd);
		apb(1'b1, lwk_pkg::A_IEN, 32'h0000_0001, rd);
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			press(lwk_pkg::K_MODE, 1'b1);
			check("mode led", 32'((i + 1) % 3 + 1), 32'(led_mode));
			check("slave mode held", 32'h0000_0000, 32'(mode));
		end
		for (int i = 0; i < 5; i++) begin
			press(lwk_pkg::K_SET, 1'b1);
			check("setting led", 32'((i + 1) % 4), 32'(led_set));
		end
		press(lwk_pkg::K_DIR, 1'b1);
		apb(1'b0, lwk_pkg::A_SEL, 32'h0000_0000, rd);
		check("direction", 32'h0000_0041, rd);
		// a whole press with the enable low must leave no trace
		ce <= 1'b0;
		press(lwk_pkg::K_MODE, 1'b0);
		ce <= 1'b1;
		repeat (10) @(posedge pclk);
		check("frozen mode led", 32'h0000_0001, 32'(led_mode));
		$display("test selection done");
		press(lwk_pkg::K_RUN, 1'b1);
		check("slave config", 32'h0000_0031, 32'({run, dir, mode, set}));
		press(lwk_pkg::K_MODE, 1'b0);
		repeat (2000) @(posedge pclk);
		apb(1'b0, lwk_pkg::A_STAT, 32'h0000_0000, rd);
		check("no frame running", 32'h0000_0000, 32'(rd[0]));
		check("mode led running", 32'h0000_0001, 32'(led_mode));
		$display("test run done");
		motor_st <= 8'hA5;
		apb(1'b1, lwk_pkg::A_CTRL, 32'h0000_0001, rd);
		wait_stat(3);
		apb(1'b0, lwk_pkg::A_RXD, 32'h0000_0000, rd);
		check("status byte", 32'h0000_00A5, rd);
		press(lwk_pkg::K_RUN, 1'b1);
		check("slave stopped", 32'h0000_0000, 32'(run));
		apb(1'b1, lwk_pkg::A_CTRL, 32'h0000_0000, rd);
		$display("test poll done");
		keys[lwk_pkg::K_MODE] <= 1'b1;
		repeat (2) @(posedge pclk);
		keys[lwk_pkg::K_MODE] <= 1'b0;
		repeat (100) @(posedge pclk);
		check("bounce ignored", 32'h0000_0001, 32'(led_mode));
		apb(1'b0, lwk_pkg::A_STAT, 32'h0000_0000, rd);
		check("no link errors", 32'h0000_0000, rd & 32'h0000_0032);
		check("slave errors", 32'h0000_0000, 32'(slave_bad));
		$display("test errors done");
		finish_test();
	end
endmodule : lin_master_wiper_keypad_bench
